// ==== rcsf_pkg.sv ====
// Package with register map, field positions and reset values
package rcsf_pkg;
	localparam int          RCSF_AW          = 8;
	localparam int          RCSF_DW          = 8;
	// Register offsets
	localparam logic [7:0]  RCSF_PRS_ADDR    = 8'h8e;
	localparam logic [7:0]  RCSF_IRQ_STAT_ADDR = 8'h90;
	localparam logic [7:0]  RCSF_IRQ_MASK_ADDR = 8'h91;
	// Fields of power_reset_status
	localparam int          RCSF_BOR_BIT     = 0;
	localparam int          RCSF_POR_BIT     = 1;
	// Fields of the event status and mask registers
	localparam int          RCSF_EV_POR      = 0;
	localparam int          RCSF_EV_BOR      = 1;
	localparam int          RCSF_EV_EXT      = 2;
	localparam int          RCSF_EV_WDT      = 3;
	localparam int          RCSF_EV_N        = 4;
	// Reset values and synchroniser width
	localparam logic        RCSF_POR_RST     = 1'b0;
	localparam logic        RCSF_BOR_RST     = 1'b0;
	localparam logic [3:0]  RCSF_EV_RST      = 4'h0;
	localparam logic [3:0]  RCSF_MASK_RST    = 4'h0;
	localparam int          RCSF_SYNC_N      = 5;
endpackage : rcsf_pkg

// ==== rcsf_sync.sv ====
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module rcsf_sync #(
	parameter int W = 1
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_reg;

	// First stage feeds only the second stage
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			meta_reg <= '0;
			o_sync   <= '0;
		end
		else
		begin
			meta_reg <= i_async;
			o_sync   <= meta_reg;
		end
	end
endmodule : rcsf_sync

// ==== rcsf_top.sv ====
// Reset-cause status flags with register port and event interrupt
`timescale 1ns/1ns
module rcsf_top
	import rcsf_pkg::*;
(
	input  wire logic                i_mclk,
	input  wire logic                i_rst_b,
	input  wire logic                i_brownout_reset,
	input  wire logic                i_external_reset_pin,
	input  wire logic                i_watchdog_reset,
	input  wire logic                i_brownout_detect_enable,
	input  wire logic [RCSF_AW-1:0]  i_addr,
	input  wire logic [RCSF_DW-1:0]  i_wr_data,
	input  wire logic                i_wr_stb,
	input  wire logic                i_rd_stb,
	output logic      [RCSF_DW-1:0]  o_rd_data,
	output logic                     o_irq
);
	logic [RCSF_SYNC_N-1:0]  sync_lvl;
	logic [2:0]              prev_reg;
	logic                    bor_en;
	logic                    bor_evt;
	logic                    ext_evt;
	logic                    wdt_evt;
	logic                    por_seen_reg;
	logic                    por_pulse;
	logic                    por_flag_reg;
	logic                    bor_flag_reg;
	logic [RCSF_EV_N-1:0]    ev_stat_reg;
	logic [RCSF_EV_N-1:0]    ev_mask_reg;
	logic [RCSF_EV_N-1:0]    ev_set;
	logic                    wr_prs;
	logic                    wr_mask;
	logic                    rd_stat;
	logic [RCSF_DW-1:0]      rd_next;

	// Reset causes and the config enable come from other domains
	rcsf_sync #(
		.W (RCSF_SYNC_N)
	) u_sync (
		.i_mclk  (i_mclk),
		.i_rst_b (i_rst_b),
		.i_async ({i_brownout_detect_enable, i_watchdog_reset,
			i_external_reset_pin, i_brownout_reset, 1'b0}),
		.o_sync  (sync_lvl)
	);

	assign bor_en = sync_lvl[4];

	// Rising edges of the synchronised reset indications
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			prev_reg <= 3'h0;
		else
			prev_reg <= sync_lvl[3:1];
	end

	// Brown-out only counts while detection is on, as the flag is void otherwise
	assign bor_evt = sync_lvl[1] & ~prev_reg[0] & bor_en;
	assign ext_evt = sync_lvl[2] & ~prev_reg[1];
	assign wdt_evt = sync_lvl[3] & ~prev_reg[2];

	// One pulse in the first cycle after power-on reset release
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			por_seen_reg <= 1'b0;
		else
			por_seen_reg <= 1'b1;
	end

	assign por_pulse = ~por_seen_reg;

	// Register port decode
	assign wr_prs  = i_wr_stb && (i_addr == RCSF_PRS_ADDR);
	assign wr_mask = i_wr_stb && (i_addr == RCSF_IRQ_MASK_ADDR);
	assign rd_stat = i_rd_stb && (i_addr == RCSF_IRQ_STAT_ADDR);

	// Power-on flag: reset clears it, software writes it; reset wins
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			por_flag_reg <= RCSF_POR_RST;
		else if (por_pulse)
			por_flag_reg <= 1'b0;
		else if (wr_prs)
			por_flag_reg <= i_wr_data[RCSF_POR_BIT];
	end

	// Brown-out flag: reset loads RCSF_BOR_RST (0), a brown-out clears it, software arms it
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			bor_flag_reg <= RCSF_BOR_RST;
		else if (bor_evt)
			bor_flag_reg <= 1'b0;
		else if (wr_prs)
			bor_flag_reg <= i_wr_data[RCSF_BOR_BIT];
	end

	// Pin and watchdog resets reach only the event status, never the flags
	always_comb
	begin
		ev_set              = '0;
		ev_set[RCSF_EV_POR] = por_pulse;
		ev_set[RCSF_EV_BOR] = bor_evt;
		ev_set[RCSF_EV_EXT] = ext_evt;
		ev_set[RCSF_EV_WDT] = wdt_evt;
	end

	// Sticky events set regardless of mask; a set beats a read-clear
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ev_stat_reg <= RCSF_EV_RST;
		else if (rd_stat)
			ev_stat_reg <= ev_set;
		else
			ev_stat_reg <= ev_stat_reg | ev_set;
	end

	// Mask register steers the interrupt output
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ev_mask_reg <= RCSF_MASK_RST;
		else if (wr_mask)
			ev_mask_reg <= i_wr_data[RCSF_EV_N-1:0];
	end

	// Level interrupt while any unmasked event is pending
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_irq <= 1'b0;
		else
			o_irq <= |((rd_stat ? ev_set : (ev_stat_reg | ev_set))
				& (wr_mask ? i_wr_data[RCSF_EV_N-1:0] : ev_mask_reg));
	end

	// Read mux; unused bits and unmapped addresses read zero
	always_comb
	begin
		rd_next = '0;
		case (i_addr)
			RCSF_PRS_ADDR:
			begin
				rd_next[RCSF_POR_BIT] = por_flag_reg;
				rd_next[RCSF_BOR_BIT] = bor_flag_reg;
			end
			RCSF_IRQ_STAT_ADDR: rd_next[RCSF_EV_N-1:0] = ev_stat_reg;
			RCSF_IRQ_MASK_ADDR: rd_next[RCSF_EV_N-1:0] = ev_mask_reg;
			default: rd_next = '0;
		endcase
	end

	// Read data stands one cycle after the strobe only
	always_ff @(posedge i_mclk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			o_rd_data <= '0;
		else if (i_rd_stb)
			o_rd_data <= rd_next;
		else
			o_rd_data <= '0;
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	a_por_flag_clear: assert property (
		por_pulse ##1 !wr_prs |=> !por_flag_reg)
		else $error("power-on flag not cleared after power-on");

	a_bor_flag_clear: assert property (
		bor_evt |=> !bor_flag_reg ##1 (!bor_flag_reg || $past(wr_prs)))
		else $error("brown-out flag not cleared by brown-out");

	a_bor_disabled_hold: assert property (
		(!bor_en && !wr_prs) |=> $stable(bor_flag_reg))
		else $error("brown-out flag moved while detection disabled");

	a_flags_readback: assert property (
		(i_rd_stb && i_addr == RCSF_PRS_ADDR) |=>
		o_rd_data[1:0] == $past({por_flag_reg, bor_flag_reg}))
		else $error("status read does not show the flags");

	a_event_sticky: assert property (
		(ext_evt && ev_mask_reg == '0) |=> ev_stat_reg[RCSF_EV_EXT]
		##1 (ev_stat_reg[RCSF_EV_EXT] || $past(rd_stat)))
		else $error("pin reset event lost while masked");

	a_irq_unmasked: assert property (
		(wdt_evt && ev_mask_reg[RCSF_EV_WDT] && !wr_mask) |=> o_irq)
		else $error("unmasked event gave no interrupt");

	a_pin_keeps_flags: assert property (
		((ext_evt || wdt_evt) && !bor_evt && !wr_prs && !por_pulse)
		|=> $stable({por_flag_reg, bor_flag_reg}))
		else $error("pin or watchdog reset changed a flag");

	a_upper_zero: assert property (
		(i_rd_stb && i_addr == RCSF_PRS_ADDR) |=> o_rd_data[7:2] == 6'h00)
		else $error("unused status bits not zero");

	// Event capture; a read in the same cycle must not lose a new event
	a_por_event_set: assert property (
		por_pulse
		|=> ev_stat_reg[RCSF_EV_POR])
		else $error("power-on event not captured");

	a_bor_event_set: assert property (
		bor_evt
		|=> ev_stat_reg[RCSF_EV_BOR])
		else $error("brown-out event not captured");

	a_ext_event_set: assert property (
		ext_evt
		|=> ev_stat_reg[RCSF_EV_EXT])
		else $error("pin reset event not captured");

	a_wdt_event_set: assert property (
		wdt_evt
		|=> ev_stat_reg[RCSF_EV_WDT])
		else $error("watchdog event not captured");

	a_ext_evt_edge: assert property (
		ext_evt
		|=> !ext_evt)
		else $error("pin reset level seen as repeated events");

	a_por_pulse_once: assert property (
		por_pulse
		|=> !por_pulse)
		else $error("power-on pulse longer than one cycle");

	a_stat_read_clear: assert property (
		(rd_stat && ev_set == '0)
		|=> ev_stat_reg == '0)
		else $error("status not cleared by its read");

	a_stat_readback: assert property (
		rd_stat
		|=> o_rd_data == {4'h0, $past(ev_stat_reg)})
		else $error("status read does not show pending events");

	// Interrupt level must track status and mask in every cycle
	a_irq_level: assert property (
		o_irq == |(ev_stat_reg & ev_mask_reg))
		else $error("interrupt level disagrees with status and mask");

	a_irq_masked_off: assert property (
		(ev_mask_reg == '0 && !wr_mask)
		|=> !o_irq)
		else $error("interrupt raised with every event masked");

	a_mask_write: assert property (
		wr_mask
		|=> ev_mask_reg == $past(i_wr_data[RCSF_EV_N-1:0]))
		else $error("mask write not taken");

	// Software writes of the flags and the read port
	a_por_flag_write: assert property (
		(wr_prs && !por_pulse)
		|=> por_flag_reg == $past(i_wr_data[RCSF_POR_BIT]))
		else $error("power-on flag write not taken");

	a_bor_flag_write: assert property (
		(wr_prs && !bor_evt)
		|=> bor_flag_reg == $past(i_wr_data[RCSF_BOR_BIT]))
		else $error("brown-out flag write not taken");

	a_flags_idle_hold: assert property (
		(!wr_prs && !bor_evt && !por_pulse)
		|=> $stable({por_flag_reg, bor_flag_reg}))
		else $error("flags changed with no cause");

	a_mask_readback: assert property (
		(i_rd_stb && i_addr == RCSF_IRQ_MASK_ADDR)
		|=> o_rd_data == {4'h0, $past(ev_mask_reg)})
		else $error("mask read wrong or upper bits set");

	a_unmapped_zero: assert property (
		(i_rd_stb && i_addr != RCSF_PRS_ADDR
		&& i_addr != RCSF_IRQ_STAT_ADDR && i_addr != RCSF_IRQ_MASK_ADDR)
		|=> o_rd_data == '0)
		else $error("unmapped read not zero");

	a_rd_idle_zero: assert property (
		!i_rd_stb
		|=> o_rd_data == '0)
		else $error("read data stands without a read");

	// Scenarios worth seeing
	c_bor_seen: cover property (bor_evt ##[1:20] rd_stat);
	c_wdt_irq: cover property (wdt_evt ##1 o_irq);
	c_bor_off: cover property (!bor_en && $rose(sync_lvl[1]));
	c_ext_irq: cover property (ext_evt ##1 o_irq);
	c_rearm: cover property (wr_prs && i_wr_data[1:0] == 2'h3);
endmodule : rcsf_top

// ==== rcsf_top_tb.sv ====
// Self-checking testbench for the reset-cause status flags
`timescale 1ns/1ns
module rcsf_top_tb;
	import rcsf_pkg::*;
	logic       i_mclk  = 1'b0;
	logic       i_rst_b = 1'b0;
	logic [2:0] ev      = 3'h0;
	logic [7:0] addr    = 8'h00;
	logic [7:0] wdat    = 8'h00;
	logic       wr      = 1'b0;
	logic       rd      = 1'b0;
	logic       bor_den = 1'b1;
	logic [7:0] rdat;
	logic       irq;
	int         error_cnt  = 0;
	int         num_checks = 0;
	int         cyc        = 0;

	// Device under test; ev bits are brown-out, pin, watchdog
	rcsf_top dut_u (
		.i_mclk(i_mclk), .i_rst_b(i_rst_b),
		.i_brownout_reset(ev[0]), .i_external_reset_pin(ev[1]),
		.i_watchdog_reset(ev[2]), .i_brownout_detect_enable(bor_den),
		.i_addr(addr), .i_wr_data(wdat), .i_wr_stb(wr), .i_rd_stb(rd),
		.o_rd_data(rdat), .o_irq(irq)
	);

	// 250 MHz clock
	initial forever #2 i_mclk = ~i_mclk;

	// Hang guard, far above the roughly 130 cycles the run needs
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic chk(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		addr <= a;
		wdat <= d;
		wr   <= 1'b1;
		@(posedge i_mclk);
		wr   <= 1'b0;
	endtask : wr_reg

	// Read data is looked at only in the cycle after the strobe
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
		input string what);
		@(posedge i_mclk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge i_mclk);
		rd   <= 1'b0;
		#1 chk(what, exp, rdat);
	endtask : rd_chk

	// Level held long enough to pass the synchroniser, then released
	task automatic pulse(input int k);
		@(posedge i_mclk);
		ev[k] <= 1'b1;
		repeat (6) @(posedge i_mclk);
		ev[k] <= 1'b0;
		repeat (3) @(posedge i_mclk);
	endtask : pulse

	task automatic por_apply();
		@(posedge i_mclk);
		i_rst_b <= 1'b0;
		repeat (8) @(posedge i_mclk);
		i_rst_b <= 1'b1;
		@(posedge i_mclk);
	endtask : por_apply

	// Main sequence
	initial
	begin
		por_apply();
		rd_chk(RCSF_PRS_ADDR, 8'h00, "flags after power-on");
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h01, "power-on event");
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h00, "status after read");
		wr_reg(RCSF_PRS_ADDR, 8'hff);
		rd_chk(RCSF_PRS_ADDR, 8'h03, "flags set by software");
		@(posedge i_mclk);
		#1 chk("read data after one cycle", 8'h00, rdat);
		pulse(1);
		pulse(2);
		rd_chk(RCSF_PRS_ADDR, 8'h03, "flags after pin, watchdog");
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h0c, "masked events");
		chk("irq while masked", 8'h00, {7'h00, irq});
		wr_reg(RCSF_IRQ_MASK_ADDR, 8'hf2);
		rd_chk(RCSF_IRQ_MASK_ADDR, 8'h02, "mask readback");
		#1 chk("irq after enable", 8'h00, {7'h00, irq});
		pulse(0);
		#1 chk("irq on brown-out", 8'h01, {7'h00, irq});
		rd_chk(RCSF_PRS_ADDR, 8'h02, "flags after brown-out");
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h02, "brown-out event");
		repeat (2) @(posedge i_mclk);
		#1 chk("irq after status read", 8'h00, {7'h00, irq});
		// Brown-out with detection off is ignored entirely
		wr_reg(RCSF_PRS_ADDR, 8'h03);
		@(posedge i_mclk);
		bor_den <= 1'b0;
		repeat (4) @(posedge i_mclk);
		pulse(0);
		rd_chk(RCSF_PRS_ADDR, 8'h03, "flags, detection off");
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h00, "event, detection off");
		@(posedge i_mclk);
		bor_den <= 1'b1;
		repeat (3) @(posedge i_mclk);
		// Unmasked watchdog event raises the interrupt
		wr_reg(RCSF_IRQ_MASK_ADDR, 8'h08);
		pulse(2);
		#1 chk("irq on watchdog", 8'h01, {7'h00, irq});
		rd_chk(RCSF_IRQ_STAT_ADDR, 8'h08, "watchdog event");
		wr_reg(8'h55, 8'hff);
		rd_chk(8'h55, 8'h00, "unmapped read");
		rd_chk(RCSF_PRS_ADDR, 8'h03, "flags after unmapped write");
		wr_reg(RCSF_PRS_ADDR, 8'h03);
		por_apply();
		rd_chk(RCSF_PRS_ADDR, 8'h00, "flags after second power-on");
		rd_chk(RCSF_IRQ_MASK_ADDR, 8'h00, "mask after reset");
		report_and_stop();
	end
endmodule : rcsf_top_tb
